// ==== rtl/cadc_pkg.sv ====
package cadc_pkg;

    // ------------------------------------------------------------------
    // Register word indices; the bus byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] CADC_OFF_CONV_STATUS = 8'h06;
    localparam logic [7:0] CADC_OFF_CHAN_SEL = 8'h07;
    localparam logic [7:0] CADC_OFF_CMP_STATUS = 8'h08;
    localparam logic [7:0] CADC_OFF_RES_LOW = 8'h04;
    localparam logic [7:0] CADC_OFF_RES_HIGH = 8'h05;
    localparam logic [7:0] CADC_OFF_SPEC_FUNC = 8'h30;

    // ------------------------------------------------------------------
    // Comparator control/status bit positions.
    // ------------------------------------------------------------------
    localparam int CADC_CMP_OFF_BIT = 7;
    localparam int CADC_CMP_BG_BIT = 6;
    localparam int CADC_CMP_OUT_BIT = 5;
    localparam int CADC_CMP_FLAG_BIT = 4;
    localparam int CADC_CMP_IE_BIT = 3;
    localparam int CADC_CMP_CAP_BIT = 2;

    // ------------------------------------------------------------------
    // Converter control/status, channel select and special function bit positions.
    // ------------------------------------------------------------------
    localparam int CADC_CONV_EN_BIT = 7;
    localparam int CADC_CONV_START_BIT = 6;
    localparam int CADC_CONV_FREE_BIT = 5;
    localparam int CADC_CONV_FLAG_BIT = 4;
    localparam int CADC_CONV_IE_BIT = 3;
    localparam int CADC_CHAN_LEFT_BIT = 5;
    localparam int CADC_SPEC_MUXEN_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values and timing counts.
    // ------------------------------------------------------------------
    localparam logic [7:0] CADC_RST_BYTE = 8'h00;
    localparam logic [4:0] CADC_CONV_CYC_NORMAL = 5'd13;
    localparam logic [4:0] CADC_CONV_CYC_FIRST = 5'd25;
    localparam logic [2:0] CADC_PRESCALE_DIV = 3'd4;

    // Channel codes for internal sources.
    localparam logic [4:0] CADC_CH_BANDGAP = 5'b11110;
    localparam logic [4:0] CADC_CH_GROUND = 5'b11111;

    // Comparator event modes.
    typedef enum logic [1:0] {
        CADC_EV_TOGGLE = 2'b00,
        CADC_EV_RESERVED = 2'b01,
        CADC_EV_FALL = 2'b10,
        CADC_EV_RISE = 2'b11
    } cadc_ev_mode_t;

    // Interrupt request bundle.
    typedef struct packed {
        logic cmp_irq;
        logic conv_irq;
        logic capture_irq;
    } cadc_irq_t;

endpackage : cadc_pkg

// ==== rtl/cadc_top.sv ====
// How it works
// RULE1: output bit high when positive exceeds negative
// RULE2: power-off bit shuts comparator down
// RULE3: bandgap drives positive input if fused
// RULE4: output bit is read-only live value
// RULE5: matching output transition sets event flag
// RULE6: irq needs flag, enable and global enable
// RULE7: flag cleared by vector or writing one
// RULE8: capture route feeds comparator to timer
// RULE9: capture irq needs timer mask bit
// RULE10: mode bits pick toggle, fall or rise
// RULE11: software disables irq before mode changes
// RULE12: mux selects converter pin as negative
// RULE13: ten-bit code, ground to reference less LSB
// RULE14: single or free-running conversion modes
// RULE15: selections wait for converter enable
// RULE16: start bit runs, reads one, self-clears
// RULE17: channel change applies after current conversion
// RULE18: right or left justified result
// RULE19: low read locks result until high read
// RULE20: software reads low byte before high
// RULE21: done flag fires even when discarded
// RULE22: thirteen cycles, first one twenty-five
// RULE23: completion stores, flags, clears or restarts
// RULE24: channel codes pins, bandgap, ground
// RULE25: prescaler runs only while enabled
// RULE26: comparator output synchronised before edges
// RULE27: locked completion still clears start, flags
//
// The AHB-Lite slave port was chosen for this implementation.
module cadc_top
    import cadc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cmp_raw,
    input wire logic brownout_detect_fuse,
    input wire logic global_irq_enable,
    input wire logic cmp_vector_ack,
    input wire logic conv_vector_ack,
    input wire logic capture_irq_mask_bit,
    input wire logic capture_event,
    input wire logic [9:0] conv_sample,
    output logic cmp_powered,
    output logic cmp_bandgap_pos,
    output logic cmp_neg_from_mux,
    output logic [2:0] cmp_neg_channel,
    output logic capture_input,
    output logic conv_active,
    output logic [4:0] conv_channel,
    output logic [1:0] conv_reference,
    output cadc_irq_t irq
);

    // ------------------------------------------------------------------
    // Bus slave front end.
    // ------------------------------------------------------------------

    // Captured address phase, kept as a word index.
    logic wr_pend_r;
    logic [7:0] addr_r;

    // Register state.
    logic [7:0] cmp_ctrl_r;
    logic [7:0] conv_ctrl_r;
    logic [7:0] chan_sel_r;
    logic spec_muxen_r;
    logic [9:0] result_r;
    logic lock_r;

    // Applied channel and reference, latched only between conversions.
    logic [4:0] chan_act_r;
    logic [1:0] ref_act_r;

    // Converter sequencing.
    logic [2:0] presc_r;
    logic [4:0] cyc_r;
    logic first_r;
    logic busy_r;

    // Comparator synchroniser and edge history.
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_s3_r;

    logic acc_ok;
    logic rd_acc;
    logic [7:0] rd_addr;
    logic done;
    logic ev_hit;
    logic tick;
    logic [7:0] wb;

    assign acc_ok = hsel && hready && htrans[1];
    assign rd_acc = acc_ok && !hwrite;
    assign rd_addr = haddr[9:2];
    assign wb = hwdata[7:0];
    // Zero wait state slave, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture the write address phase for the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= acc_ok && hwrite;
            addr_r <= acc_ok ? haddr[9:2] : addr_r;
        end
    end

    // Read data is registered at the address phase so it stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (rd_addr)
                // RULE4: live output bit
                CADC_OFF_CMP_STATUS: hrdata <= {24'h00_0000, cmp_ctrl_r[7:6], cmp_s2_r,
                                                cmp_ctrl_r[4:0]};
                CADC_OFF_CONV_STATUS: hrdata <= {24'h00_0000, conv_ctrl_r};
                CADC_OFF_CHAN_SEL: hrdata <= {24'h00_0000, chan_sel_r};
                CADC_OFF_SPEC_FUNC: hrdata <= {28'h000_0000, spec_muxen_r, 3'b000};
                // RULE18: justification applied on read
                CADC_OFF_RES_LOW: hrdata <= chan_sel_r[CADC_CHAN_LEFT_BIT] ?
                    {24'h00_0000, result_r[1:0], 6'b00_0000} : {24'h00_0000, result_r[7:0]};
                CADC_OFF_RES_HIGH: hrdata <= chan_sel_r[CADC_CHAN_LEFT_BIT] ?
                    {24'h00_0000, result_r[9:2]} : {30'h0000_0000, result_r[9:8]};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Comparator.
    // ------------------------------------------------------------------

    // RULE26: two-stage sync then history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_raw;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
        end
    end

    // RULE10: event mode decode; reserved never fires.
    always_comb begin
        case (cadc_ev_mode_t'(cmp_ctrl_r[1:0]))
            CADC_EV_TOGGLE: ev_hit = cmp_s2_r ^ cmp_s3_r;
            CADC_EV_FALL: ev_hit = !cmp_s2_r && cmp_s3_r;
            CADC_EV_RISE: ev_hit = cmp_s2_r && !cmp_s3_r;
            default: ev_hit = 1'b0;
        endcase
    end

    // Comparator control register; the flag's set wins over any clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_ctrl_r <= CADC_RST_BYTE;
        end else begin
            if (wr_pend_r && addr_r == CADC_OFF_CMP_STATUS) begin
                // RULE2: power-off written at any time
                cmp_ctrl_r[7:6] <= wb[7:6];
                cmp_ctrl_r[3:0] <= wb[3:0];
            end
            // RULE5: qualifying edge sets the flag
            if (ev_hit) begin
                cmp_ctrl_r[CADC_CMP_FLAG_BIT] <= 1'b1;
            // RULE7: vector or write-one clears
            end else if (cmp_vector_ack ||
                         (wr_pend_r && addr_r == CADC_OFF_CMP_STATUS && wb[4])) begin
                cmp_ctrl_r[CADC_CMP_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // RULE1: analog result arrives as cmp_raw
    assign cmp_powered = !cmp_ctrl_r[CADC_CMP_OFF_BIT];
    // RULE3: bandgap only with brown-out fuse
    assign cmp_bandgap_pos = cmp_ctrl_r[CADC_CMP_BG_BIT] && brownout_detect_fuse;
    // RULE12: mux only while converter off
    assign cmp_neg_from_mux = spec_muxen_r && !conv_ctrl_r[CADC_CONV_EN_BIT];
    assign cmp_neg_channel = chan_sel_r[2:0];
    // RULE8: route output to capture front end
    assign capture_input = cmp_ctrl_r[CADC_CMP_CAP_BIT] && cmp_s2_r;

    // RULE6: flag, enable and global enable
    // RULE9: capture gated by timer mask
    assign irq = '{cmp_irq: cmp_ctrl_r[CADC_CMP_FLAG_BIT] && cmp_ctrl_r[CADC_CMP_IE_BIT]
                            && global_irq_enable,
                   conv_irq: conv_ctrl_r[CADC_CONV_FLAG_BIT] && conv_ctrl_r[CADC_CONV_IE_BIT]
                             && global_irq_enable,
                   capture_irq: capture_event && capture_irq_mask_bit && global_irq_enable};

    // ------------------------------------------------------------------
    // Converter sequencing.
    // ------------------------------------------------------------------

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spec_muxen_r <= 1'b0;
            chan_sel_r <= CADC_RST_BYTE;
        end else if (wr_pend_r) begin
            if (addr_r == CADC_OFF_SPEC_FUNC) begin
                spec_muxen_r <= wb[CADC_SPEC_MUXEN_BIT];
            end
            if (addr_r == CADC_OFF_CHAN_SEL) begin
                chan_sel_r <= wb;
            end
        end
    end

    // RULE25: prescaler held while disabled
    assign tick = conv_ctrl_r[CADC_CONV_EN_BIT] && presc_r == CADC_PRESCALE_DIV - 3'd1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= 3'd0;
        end else if (!conv_ctrl_r[CADC_CONV_EN_BIT] || tick) begin
            presc_r <= 3'd0;
        end else begin
            presc_r <= presc_r + 3'd1;
        end
    end

    // RULE22: thirteen or twenty-five ticks
    assign done = busy_r && tick &&
                  cyc_r == (first_r ? CADC_CONV_CYC_FIRST : CADC_CONV_CYC_NORMAL);

    // Conversion counter; starts on a tick once the start bit stands.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
            cyc_r <= 5'd0;
            first_r <= 1'b1;
            chan_act_r <= 5'd0;
            ref_act_r <= 2'd0;
        end else if (!conv_ctrl_r[CADC_CONV_EN_BIT]) begin
            busy_r <= 1'b0;
            cyc_r <= 5'd0;
            first_r <= 1'b1;
        end else if (tick) begin
            if (done) begin
                first_r <= 1'b0;
                // RULE14: free-run restarts immediately
                busy_r <= conv_ctrl_r[CADC_CONV_FREE_BIT];
                cyc_r <= 5'd1;
            end else if (busy_r) begin
                cyc_r <= cyc_r + 5'd1;
            end else if (conv_ctrl_r[CADC_CONV_START_BIT]) begin
                busy_r <= 1'b1;
                cyc_r <= 5'd1;
            end
            // RULE15: selections apply only when enabled
            // RULE17: deferred until not converting
            if (!busy_r || done) begin
                chan_act_r <= chan_sel_r[4:0];
                ref_act_r <= chan_sel_r[7:6];
            end
        end
    end

    // RULE24: channel code passes to the analog mux
    assign conv_channel = chan_act_r;
    assign conv_reference = ref_act_r;
    assign conv_active = busy_r;

    // Converter control register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_ctrl_r <= CADC_RST_BYTE;
        end else begin
            if (wr_pend_r && addr_r == CADC_OFF_CONV_STATUS) begin
                conv_ctrl_r[7] <= wb[7];
                conv_ctrl_r[5] <= wb[5];
                conv_ctrl_r[3:0] <= wb[3:0];
                // RULE16: writing one starts
                if (wb[CADC_CONV_START_BIT]) begin
                    conv_ctrl_r[CADC_CONV_START_BIT] <= 1'b1;
                end
            end
            // RULE23: single mode clears start on done
            // RULE27: even when result discarded
            if (done && !conv_ctrl_r[CADC_CONV_FREE_BIT]) begin
                conv_ctrl_r[CADC_CONV_START_BIT] <= 1'b0;
            end
            // Disabling aborts any conversion in flight.
            if (wr_pend_r && addr_r == CADC_OFF_CONV_STATUS && !wb[CADC_CONV_EN_BIT]) begin
                conv_ctrl_r[CADC_CONV_START_BIT] <= 1'b0;
            end
            // RULE21: done flag set regardless of lock
            if (done) begin
                conv_ctrl_r[CADC_CONV_FLAG_BIT] <= 1'b1;
            end else if (conv_vector_ack ||
                         (wr_pend_r && addr_r == CADC_OFF_CONV_STATUS && wb[4])) begin
                conv_ctrl_r[CADC_CONV_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // RULE19: low read locks, high read unlocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_r <= 1'b0;
        end else if (rd_acc && rd_addr == CADC_OFF_RES_HIGH) begin
            lock_r <= 1'b0;
        end else if (rd_acc && rd_addr == CADC_OFF_RES_LOW) begin
            lock_r <= 1'b1;
        end
    end

    // RULE13: ten-bit code stored as sampled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= 10'd0;
        end else if (done && !lock_r) begin
            result_r <= conv_sample;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_flag_on_rise: assert property (   // RULE5
        cmp_ctrl_r[1:0] == 2'b11 && cmp_s2_r && !cmp_s3_r |=> cmp_ctrl_r[4])
        else $error("rise did not set event flag");
    a_cmp_irq_gate: assert property (   // RULE6
        irq.cmp_irq |-> cmp_ctrl_r[4] && cmp_ctrl_r[3] && global_irq_enable)
        else $error("comparator irq without all enables");
    a_reserved_mode: assert property (   // RULE10
        cmp_ctrl_r[1:0] == 2'b01 && !cmp_ctrl_r[4] && !(wr_pend_r) |=> !cmp_ctrl_r[4])
        else $error("reserved mode set flag");
    a_vector_clear: assert property (   // RULE7
        cmp_vector_ack && !ev_hit |=> !cmp_ctrl_r[4])
        else $error("vector did not clear flag");
    a_mux_route: assert property (   // RULE12
        conv_ctrl_r[7] |-> !cmp_neg_from_mux)
        else $error("mux used while converter enabled");
    a_capture_route: assert property (   // RULE8
        !cmp_ctrl_r[2] |-> !capture_input)
        else $error("capture routed while disabled");
    a_lock_hold: assert property (   // RULE19
        lock_r && !rd_acc |=> $stable(result_r))
        else $error("result changed while locked");
    a_done_flag: assert property (   // RULE21
        done |=> conv_ctrl_r[4])
        else $error("done flag missing");
    a_start_clear: assert property (   // RULE23
        done && !conv_ctrl_r[5] && !wr_pend_r |=> !conv_ctrl_r[6])
        else $error("start bit not cleared");
    a_presc_hold: assert property (   // RULE25
        !conv_ctrl_r[7] |=> presc_r == 3'd0)
        else $error("prescaler ran while disabled");
    a_chan_defer: assert property (   // RULE17
        busy_r && !done |=> $stable(chan_act_r))
        else $error("channel changed mid conversion");

    c_cmp_irq: cover property (irq.cmp_irq);
    c_done_locked: cover property (done && lock_r);
    c_free_run: cover property (done && conv_ctrl_r[5]);
    c_first_done: cover property (done && first_r);

endmodule // cadc_top

// ==== verif/cadc_far_model.sv ====
// ------------------------------------------------------------------
// Analog front end and timer capture stand-in.
// ------------------------------------------------------------------
module cadc_far_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cmp_level,
    input wire logic [4:0] conv_channel,
    input wire logic capture_input,
    output logic cmp_raw,
    output logic [9:0] conv_sample,
    output logic capture_event
);
    timeunit 1ns;
    timeprecision 1ns;

    // Previous capture input, for the timer's rising edge select.
    logic cap_prev_r;

    assign cmp_raw = cmp_level;

    // Each channel gives its own code, so a stale channel shows up in the result.
    // ten-bit code
    assign conv_sample = {conv_channel, ~conv_channel};

    // The timer front end pulses once on each rising capture input.
    // edge select front
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_prev_r <= 1'b0;
            capture_event <= 1'b0;
        end else begin
            cap_prev_r <= capture_input;
            capture_event <= capture_input & ~cap_prev_r;
        end
    end
endmodule // cadc_far_model

// ==== verif/cadc_top_tb.sv ====
// ------------------------------------------------------------------
// Register level bench for the comparator and converter control.
// ------------------------------------------------------------------
module cadc_top_tb;
    import cadc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic cmp_raw, brownout_detect_fuse, global_irq_enable, cmp_vector_ack, conv_vector_ack;
    logic capture_irq_mask_bit, capture_event, cmp_powered, cmp_bandgap_pos;
    logic cmp_neg_from_mux, capture_input, conv_active, cmp_level;
    logic [9:0] conv_sample;
    logic [2:0] cmp_neg_channel;
    logic [4:0] conv_channel;
    logic [1:0] conv_reference;
    cadc_irq_t irq;
    logic cap_seen = 1'b0; // Sticky record of a capture interrupt pulse.
    logic [9:0] s3 = {5'd3, ~5'd3}; // Expected code of channel 3.
    logic [9:0] s5 = {5'd5, ~5'd5}; // Expected code of channel 5.
    int fail_count = 0;
    int num_checks = 0;
    int n;

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    cadc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw),
        .brownout_detect_fuse(brownout_detect_fuse), .global_irq_enable(global_irq_enable),
        .cmp_vector_ack(cmp_vector_ack), .conv_vector_ack(conv_vector_ack),
        .capture_irq_mask_bit(capture_irq_mask_bit), .capture_event(capture_event),
        .conv_sample(conv_sample), .cmp_powered(cmp_powered),
        .cmp_bandgap_pos(cmp_bandgap_pos), .cmp_neg_from_mux(cmp_neg_from_mux),
        .cmp_neg_channel(cmp_neg_channel), .capture_input(capture_input),
        .conv_active(conv_active), .conv_channel(conv_channel),
        .conv_reference(conv_reference), .irq(irq));

    cadc_far_model far_u (.hclk(hclk), .hresetn(hresetn), .cmp_level(cmp_level),
        .conv_channel(conv_channel), .capture_input(capture_input), .cmp_raw(cmp_raw),
        .conv_sample(conv_sample), .capture_event(capture_event));

    // ------------------------------------------------------------------
    // Clock, monitors and shared tasks.
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // The capture interrupt is only a pulse, so it is latched for later checking.
    always @(posedge hclk) cap_seen <= cap_seen | (irq.capture_irq === 1'b1);

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits for ready at a rising edge; a stuck bus ends the run.
    task automatic wait_rdy();
        int k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            $display("[FAIL] %0t bus never ready", $time);
            close_out();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, a, 2'b00};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Moves the analog relation, then lets the synchroniser settle.
    task automatic set_cmp(input logic v);
        @(posedge hclk);
        cmp_level <= v;
        repeat (8) @(posedge hclk);
    endtask

    // Counts the busy cycles of one conversion, bounded both ways.
    task automatic conv_wait(output int cnt);
        int k = 0;
        cnt = 0;
        while (conv_active !== 1'b1 && k < 200) begin
            @(posedge hclk);
            k++;
        end
        while (conv_active === 1'b1 && cnt < 400) begin
            @(posedge hclk);
            cnt++;
        end
        if (k >= 200 || cnt >= 400) begin
            fail_count++;
            $display("[FAIL] %0t conversion hung", $time);
            close_out();
        end
    endtask

    // Polls the converter status until the done flag shows.
    task automatic flag_wait();
        logic [31:0] q = 32'h0;
        int k = 0;
        while (q[4] !== 1'b1 && k < 60) begin
            bus(1'b0, CADC_OFF_CONV_STATUS, 32'h0, q);
            k++;
        end
        chk(32'(k < 60), 32'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] q;
        {hsel, hwrite, cmp_level, brownout_detect_fuse, global_irq_enable} = 5'b0;
        {cmp_vector_ack, conv_vector_ack, capture_irq_mask_bit} = 3'b0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'b010;
        hresetn = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, with the live output bit masked, and an unmapped read.
        rdc(CADC_OFF_CONV_STATUS, 32'h0);
        rdc(CADC_OFF_CHAN_SEL, 32'h0);
        bus(1'b0, CADC_OFF_CMP_STATUS, 32'h0, q);
        chk(q & 32'hDF, 32'h0);
        rdc(8'h10, 32'h0);
        $display("test reset finished");
        // Every event mode against one rise and one fall; enable stays clear.
        for (int m = 0; m < 4; m++) begin
            wr(CADC_OFF_CMP_STATUS, 32'h10 | m);
            set_cmp(1'b1);
            rdc(CADC_OFF_CMP_STATUS, {26'h0, 1'b1, m == 0 || m == 3, 2'b0, m[1:0]});
            wr(CADC_OFF_CMP_STATUS, 32'h10 | m);
            set_cmp(1'b0);
            rdc(CADC_OFF_CMP_STATUS, {26'h0, 1'b0, m == 0 || m == 2, 2'b0, m[1:0]});
        end
        $display("test event modes finished");
        // Request gating by the global enable, then clearing by the vector.
        wr(CADC_OFF_CMP_STATUS, 32'h0B);
        set_cmp(1'b1);
        @(negedge hclk);
        chk(irq.cmp_irq, 1'b0);
        @(posedge hclk);
        global_irq_enable <= 1'b1;
        @(negedge hclk);
        chk(irq.cmp_irq, 1'b1);
        @(posedge hclk);
        cmp_vector_ack <= 1'b1;
        @(posedge hclk);
        cmp_vector_ack <= 1'b0;
        @(negedge hclk);
        chk(irq.cmp_irq, 1'b0);
        rdc(CADC_OFF_CMP_STATUS, 32'h2B);
        wr(CADC_OFF_CMP_STATUS, 32'h03);
        $display("test comparator irq finished");
        // Bandgap select, capture routing and the timer mask.
        wr(CADC_OFF_CMP_STATUS, 32'h47);
        @(negedge hclk);
        chk(cmp_bandgap_pos, 1'b0);
        chk(capture_input, 1'b1);
        @(posedge hclk);
        brownout_detect_fuse <= 1'b1;
        @(negedge hclk);
        chk(cmp_bandgap_pos, 1'b1);
        set_cmp(1'b0);
        set_cmp(1'b1);
        chk(cap_seen, 1'b0);
        capture_irq_mask_bit <= 1'b1;
        set_cmp(1'b0);
        set_cmp(1'b1);
        chk(cap_seen, 1'b1);
        wr(CADC_OFF_CMP_STATUS, 32'h83);
        @(negedge hclk);
        chk(capture_input, 1'b0);
        chk(cmp_powered, 1'b0);
        wr(CADC_OFF_CMP_STATUS, 32'h03);
        $display("test capture finished");
        // Negative input from the converter pins while the converter is off.
        wr(CADC_OFF_SPEC_FUNC, 32'h08);
        wr(CADC_OFF_CHAN_SEL, 32'h05);
        @(negedge hclk);
        chk(cmp_neg_from_mux, 1'b1);
        chk(cmp_neg_channel, 3'd5);
        chk(conv_channel, 5'd0);
        wr(CADC_OFF_CHAN_SEL, 32'h03);
        // The first conversion after enable is the extended one.
        wr(CADC_OFF_CONV_STATUS, 32'hC0);
        conv_wait(n);
        chk(32'(n >= 96 && n <= 104), 32'h1);
        chk(conv_channel, 5'd3);
        chk(cmp_neg_from_mux, 1'b0);
        rdc(CADC_OFF_CONV_STATUS, 32'h90);
        rdc(CADC_OFF_RES_LOW, {24'h0, s3[7:0]});
        rdc(CADC_OFF_RES_HIGH, {30'h0, s3[9:8]});
        // A channel written mid conversion waits for its end.
        wr(CADC_OFF_CONV_STATUS, 32'hD0);
        wr(CADC_OFF_CHAN_SEL, 32'h45);
        @(negedge hclk);
        chk(conv_channel, 5'd3);
        conv_wait(n);
        chk(32'(n >= 48 && n <= 56), 32'h1);
        chk(conv_channel, 5'd5);
        chk(conv_reference, 2'd1);
        $display("test single conversion finished");
        // Low read locks; the next result is lost but still flagged.
        rdc(CADC_OFF_RES_LOW, {24'h0, s3[7:0]});
        wr(CADC_OFF_CONV_STATUS, 32'hD8);
        conv_wait(n);
        rdc(CADC_OFF_CONV_STATUS, 32'h98);
        @(negedge hclk);
        chk(irq.conv_irq, 1'b1);
        rdc(CADC_OFF_RES_HIGH, {30'h0, s3[9:8]});
        wr(CADC_OFF_CONV_STATUS, 32'hD0);
        conv_wait(n);
        rdc(CADC_OFF_RES_LOW, {24'h0, s5[7:0]});
        rdc(CADC_OFF_RES_HIGH, {30'h0, s5[9:8]});
        wr(CADC_OFF_CHAN_SEL, 32'h25);
        rdc(CADC_OFF_RES_LOW, {24'h0, s5[1:0], 6'h0});
        rdc(CADC_OFF_RES_HIGH, {24'h0, s5[9:2]});
        $display("test result lock finished");
        // Free running keeps converting with the start bit left high.
        wr(CADC_OFF_CONV_STATUS, 32'hF0);
        flag_wait();
        wr(CADC_OFF_CONV_STATUS, 32'hB0);
        flag_wait();
        rdc(CADC_OFF_CONV_STATUS, 32'hF0);
        wr(CADC_OFF_CONV_STATUS, 32'h10);
        $display("test free run finished");
        close_out();
    end
endmodule // cadc_top_tb
